/* rtl/ckc_pkg.sv */
// Shared constants and carriers for the clock source and start-up control block
package ckc_pkg;

	// Clock rate of clk
	localparam int CLK_HZ = 20000000;

	// Fuse source codes on bits 3,2,1
	typedef enum logic [3:0] {
		CKC_SRC_LPXTAL = 4'h1,
		CKC_SRC_RECOV = 4'h2,
		CKC_SRC_EXT = 4'h4,
		CKC_SRC_RSVD = 4'h8
	} ckc_src_e;

	// Control register field positions
	localparam int MUX_SEL_BIT = 7;
	localparam int STABLE_BIT = 1;
	localparam int PLL_EN_BIT = 0;
	localparam logic [7:0] PLL_CTRL_RESET = 8'h00;

	// Watchdog oscillator time-out counts
	localparam logic [13:0] TOUT_CYC_0 = 14'h0000;
	localparam logic [13:0] TOUT_CYC_512 = 14'h0200;
	localparam logic [13:0] TOUT_CYC_8K = 14'h2000;

	// Start-up counts in oscillator clocks
	localparam logic [8:0] SU_CK_33 = 9'h021;
	localparam logic [8:0] SU_CK_40 = 9'h028;
	localparam logic [8:0] SU_CK_42 = 9'h02A;
	localparam logic [8:0] SU_CK_45 = 9'h02D;
	localparam logic [8:0] SU_CK_287 = 9'h11F;

	// Recovery divider and PLL lock time
	localparam logic [3:0] RECOV_DIV = 4'hC;
	localparam int LOCK_TIME_US = 100;
	localparam int LOCK_CYC = (LOCK_TIME_US * (CLK_HZ / 1000000)) - 1;
	localparam logic [11:0] LOCK_CYC_W = 12'(LOCK_CYC);

	// Flash write timebase: 10 MHz from 20 MHz is every second cycle
	localparam int FLASH_HZ = 10000000;
	localparam logic [3:0] FLASH_DIV_M1 = 4'(CLK_HZ / FLASH_HZ - 1);

	typedef struct packed {
		logic src_b3;
		logic src_b2;
		logic src_b1;
		logic src_b0;
		logic [1:0] startup_time;
		logic clk_out;
	} ckc_fuse_s;

	typedef struct packed {
		logic [13:0] tout_cycles;
		logic [8:0] reset_ck;
		logic [8:0] wake_ck;
	} ckc_timing_s;

endpackage

/* rtl/ckc_clock_source_startup_control.sv */
// Clock source select, start-up timing and PLL switching logic
// How it works
// - USB clock is main clock halved, only while PLL is selected.
// - Main multiplexer selects base clock after reset.
// - Source fuses b3..b1: 1x0 crystal, 1x1 recovery, 000 external, others reserved.
// - Internal reset held for 0, 512 or 8192 watchdog oscillator cycles.
// - Counter on oscillator ticks keeps reset asserted for the start-up count.
// - Reset start-up adds time-out; wake start-up uses only the start-up count.
// - Crystal: fuse b0 plus start-up fuses pick a fixed wake/reset pair.
// - All three source fuses programmed selects the external clock input.
// - External: 00 45CK, 01 plus 4 ms, 10 plus 64 ms, 11 reserved.
// - Recovery mode: base clock is the 96 MHz recovered clock divided by 12.
// - Recovery mode switching uses the same enable, lock, switch sequence.
// - PLL enable starts stabilisation; stable flag sets after lock.
// - Mux select moves main clock to PLL; software waits for stable first.
// - Clearing mux select returns the main clock to the base clock.
// - clk divided by 2 (every second cycle) provides the Flash write timebase.
// - Clock output fuse drives core clock on its pin, also during reset.
// - Control register: bit 7 select, bit 1 stable, bit 0 enable.
`timescale 1ns/1ps

module ckc_clock_source_startup_control (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ckc_pkg::ckc_fuse_s fuses,
	input wire logic ext_reset_req,
	input wire logic wake_req,
	input wire logic wdt_osc_tick,
	input wire logic osc_tick,
	input wire logic recov_tick,
	input wire logic core_clk_level,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	output logic [7:0] pll_control_reg,
	output logic main_clock_select,
	output logic pll_enable,
	output logic pll_stable,
	output logic base_clock_tick,
	output logic usb_clock_tick,
	output logic flash_clk_tick,
	output logic internal_reset,
	output logic startup_busy,
	output logic src_reserved,
	output logic [3:0] src_onehot,
	output logic clock_output_pin,
	output logic clock_output_oe
);

	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_TOUT = 4'h2,
		ST_START = 4'h4,
		ST_RUN = 4'h8
	} ckc_state_e;

	// Fuse decode shared by timing and source outputs
	function automatic ckc_pkg::ckc_src_e decode_src(input ckc_pkg::ckc_fuse_s f);
		if (f.src_b3 && !f.src_b1) begin
			decode_src = ckc_pkg::CKC_SRC_LPXTAL;
		end else if (f.src_b3) begin
			decode_src = ckc_pkg::CKC_SRC_RECOV;
		end else if (!f.src_b2 && !f.src_b1) begin
			decode_src = ckc_pkg::CKC_SRC_EXT;
		end else begin
			decode_src = ckc_pkg::CKC_SRC_RSVD;
		end
	endfunction

	// Reset delays in ms become watchdog cycles (512 per ~4 ms, 8K per ~64 ms)
	function automatic ckc_pkg::ckc_timing_s decode_timing(input ckc_pkg::ckc_fuse_s f);
		ckc_pkg::ckc_timing_s t;
		t = '0;
		case (decode_src(f))
			ckc_pkg::CKC_SRC_LPXTAL: begin
				case ({f.src_b0, f.startup_time})
					3'h0: t = '{ckc_pkg::TOUT_CYC_512, ckc_pkg::SU_CK_33, ckc_pkg::SU_CK_33};
					3'h1: t = '{ckc_pkg::TOUT_CYC_8K, ckc_pkg::SU_CK_33, ckc_pkg::SU_CK_33};
					3'h2: t = '{ckc_pkg::TOUT_CYC_0, ckc_pkg::SU_CK_42, ckc_pkg::SU_CK_40};
					3'h3: t = '{ckc_pkg::TOUT_CYC_512, ckc_pkg::SU_CK_40, ckc_pkg::SU_CK_40};
					3'h4: t = '{ckc_pkg::TOUT_CYC_8K, ckc_pkg::SU_CK_40, ckc_pkg::SU_CK_40};
					3'h5: t = '{ckc_pkg::TOUT_CYC_0, ckc_pkg::SU_CK_45, ckc_pkg::SU_CK_287};
					3'h6: t = '{ckc_pkg::TOUT_CYC_512, ckc_pkg::SU_CK_287, ckc_pkg::SU_CK_287};
					default: t = '{ckc_pkg::TOUT_CYC_8K, ckc_pkg::SU_CK_287, ckc_pkg::SU_CK_287};
				endcase
			end
			ckc_pkg::CKC_SRC_EXT: begin
				// External table; reserved code falls back to shortest
				case (f.startup_time)
					2'h1: t = '{ckc_pkg::TOUT_CYC_512, ckc_pkg::SU_CK_45, ckc_pkg::SU_CK_42};
					2'h2: t = '{ckc_pkg::TOUT_CYC_8K, ckc_pkg::SU_CK_45, ckc_pkg::SU_CK_42};
					default: t = '{ckc_pkg::TOUT_CYC_0, ckc_pkg::SU_CK_45, ckc_pkg::SU_CK_42};
				endcase
			end
			default: begin
				t = '{ckc_pkg::TOUT_CYC_8K, ckc_pkg::SU_CK_287, ckc_pkg::SU_CK_287};
			end
		endcase
		decode_timing = t;
	endfunction

	ckc_state_e state_r, state_nxt;
	logic [13:0] tout_cnt_r, tout_cnt_nxt;
	logic [8:0] su_cnt_r, su_cnt_nxt;
	logic irst_r, irst_nxt;
	logic busy_r, busy_nxt;
	logic sel_r, sel_nxt;
	logic en_r, en_nxt;
	logic stable_r, stable_nxt;
	logic [11:0] lock_cnt_r, lock_cnt_nxt;
	logic [3:0] rdiv_r, rdiv_nxt;
	logic base_r, base_nxt;
	logic half_r, half_nxt;
	logic usb_r, usb_nxt;
	logic [3:0] fdiv_r, fdiv_nxt;
	logic ftick_r, ftick_nxt;
	logic rsvd_r, rsvd_nxt;
	logic [3:0] onehot_r, onehot_nxt;
	logic cko_r, cko_nxt;
	logic ckoe_r, ckoe_nxt;
	ckc_pkg::ckc_timing_s tim;
	ckc_pkg::ckc_src_e src;

	always_comb begin
		tim = decode_timing(fuses);
		src = decode_src(fuses);
	end

	// Start-up sequencer
	always_comb begin
		state_nxt = state_r;
		tout_cnt_nxt = tout_cnt_r;
		su_cnt_nxt = su_cnt_r;
		irst_nxt = irst_r;
		if (ext_reset_req) begin
			// Hold while any other reset source is active
			state_nxt = ST_HOLD;
			irst_nxt = 1'b1;
		end else begin
			case (state_r)
				ST_HOLD: begin
					tout_cnt_nxt = tim.tout_cycles;
					su_cnt_nxt = tim.reset_ck;
					irst_nxt = 1'b1;
					state_nxt = ST_TOUT;
				end
				ST_TOUT: begin
					if (tout_cnt_r == '0) begin
						state_nxt = ST_START;
					end else if (wdt_osc_tick) begin
						tout_cnt_nxt = tout_cnt_r - 14'h0001;
					end
				end
				ST_START: begin
					if (su_cnt_r == '0) begin
						irst_nxt = 1'b0;
						state_nxt = ST_RUN;
					end else if (osc_tick) begin
						su_cnt_nxt = su_cnt_r - 9'h001;
					end
				end
				ST_RUN: begin
					// Wake uses only the start-up count
					if (wake_req) begin
						su_cnt_nxt = tim.wake_ck;
						state_nxt = ST_START;
					end
				end
				default: begin
					state_nxt = ST_HOLD;
					irst_nxt = 1'b1;
				end
			endcase
		end
		busy_nxt = (state_nxt != ST_RUN);
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= ST_HOLD;
			tout_cnt_r <= '0;
			su_cnt_r <= '0;
			irst_r <= 1'b1;
			busy_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			tout_cnt_r <= tout_cnt_nxt;
			su_cnt_r <= su_cnt_nxt;
			irst_r <= irst_nxt;
			busy_r <= busy_nxt;
		end
	end

	// PLL control and lock model
	always_comb begin
		sel_nxt = sel_r;
		en_nxt = en_r;
		stable_nxt = stable_r;
		lock_cnt_nxt = lock_cnt_r;
		if (irst_r) begin
			sel_nxt = 1'b0;
			en_nxt = 1'b0;
			stable_nxt = 1'b0;
			lock_cnt_nxt = '0;
		end else begin
			if (ctrl_wr) begin
				// Select PLL; clearing returns to base clock
				sel_nxt = ctrl_wdata[ckc_pkg::MUX_SEL_BIT];
				en_nxt = ctrl_wdata[ckc_pkg::PLL_EN_BIT];
			end
			// Disable drops the flag and restarts lock timing
			if (!en_nxt) begin
				stable_nxt = 1'b0;
				lock_cnt_nxt = '0;
			// Flag after stabilisation; same for recovery clock
			end else if (lock_cnt_r == ckc_pkg::LOCK_CYC_W) begin
				stable_nxt = 1'b1;
			end else begin
				lock_cnt_nxt = lock_cnt_r + 12'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sel_r <= ckc_pkg::PLL_CTRL_RESET[ckc_pkg::MUX_SEL_BIT];
			en_r <= ckc_pkg::PLL_CTRL_RESET[ckc_pkg::PLL_EN_BIT];
			stable_r <= ckc_pkg::PLL_CTRL_RESET[ckc_pkg::STABLE_BIT];
			lock_cnt_r <= '0;
		end else begin
			sel_r <= sel_nxt;
			en_r <= en_nxt;
			stable_r <= stable_nxt;
			lock_cnt_r <= lock_cnt_nxt;
		end
	end

	// Clock enables and pin outputs
	always_comb begin
		rdiv_nxt = rdiv_r;
		base_nxt = 1'b0;
		half_nxt = half_r;
		usb_nxt = 1'b0;
		fdiv_nxt = fdiv_r + 4'h1;
		ftick_nxt = 1'b0;
		// Recovered clock divided by 12 for base clock
		if (src == ckc_pkg::CKC_SRC_RECOV) begin
			if (recov_tick) begin
				if (rdiv_r == ckc_pkg::RECOV_DIV - 4'h1) begin
					rdiv_nxt = '0;
					base_nxt = 1'b1;
				end else begin
					rdiv_nxt = rdiv_r + 4'h1;
				end
			end
		end else begin
			rdiv_nxt = '0;
			base_nxt = osc_tick;
		end
		// Halve main clock only while PLL selected
		if (sel_r && recov_tick) begin
			half_nxt = !half_r;
			usb_nxt = half_r;
		end else if (!sel_r) begin
			half_nxt = 1'b0;
		end
		if (fdiv_r == ckc_pkg::FLASH_DIV_M1) begin
			fdiv_nxt = '0;
			ftick_nxt = 1'b1;
		end
		rsvd_nxt = (src == ckc_pkg::CKC_SRC_RSVD);
		onehot_nxt = src;
		// Core clock on pin while fuse programmed, reset included
		cko_nxt = !fuses.clk_out && core_clk_level;
		ckoe_nxt = !fuses.clk_out;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdiv_r <= '0;
			base_r <= 1'b0;
			half_r <= 1'b0;
			usb_r <= 1'b0;
			fdiv_r <= '0;
			ftick_r <= 1'b0;
			rsvd_r <= 1'b0;
			onehot_r <= '0;
			cko_r <= 1'b0;
			ckoe_r <= 1'b0;
		end else begin
			rdiv_r <= rdiv_nxt;
			base_r <= base_nxt;
			half_r <= half_nxt;
			usb_r <= usb_nxt;
			fdiv_r <= fdiv_nxt;
			ftick_r <= ftick_nxt;
			rsvd_r <= rsvd_nxt;
			onehot_r <= onehot_nxt;
			cko_r <= cko_nxt;
			ckoe_r <= ckoe_nxt;
		end
	end

	always_comb begin
		// Register image, reserved bits read zero
		pll_control_reg = {sel_r, 5'h00, stable_r, en_r};
		main_clock_select = sel_r;
		pll_enable = en_r;
		pll_stable = stable_r;
		base_clock_tick = base_r;
		usb_clock_tick = usb_r;
		flash_clk_tick = ftick_r;
		internal_reset = irst_r;
		startup_busy = busy_r;
		src_reserved = rsvd_r;
		src_onehot = onehot_r;
		clock_output_pin = cko_r;
		clock_output_oe = ckoe_r;
	end

endmodule

/* testbench/ckc_osc_model.sv */
// Behavioural clock sources seen by the control block
`timescale 1ns/1ps
module ckc_osc_model #(
	parameter int OSC_DIV = 2,
	parameter int WDT_DIV = 2
) (
	input wire logic clk,
	output logic osc_tick,
	output logic wdt_osc_tick,
	output logic recov_tick,
	output logic core_clk_level
);
	int oc = 0;
	int wc = 0;
	initial begin
		osc_tick = 1'b0;
		wdt_osc_tick = 1'b0;
		recov_tick = 1'b0;
		core_clk_level = 1'b0;
	end
	// fixed period source
	// A constant period keeps the cycle-to-cycle change well inside the limit
	always @(posedge clk) begin
		oc <= (oc + 1) % OSC_DIV;
		wc <= (wc + 1) % WDT_DIV;
		osc_tick <= (oc == OSC_DIV - 1);
		wdt_osc_tick <= (wc == WDT_DIV - 1);
		recov_tick <= 1'b1;
		core_clk_level <= ~core_clk_level;
	end
endmodule

/* testbench/ckc_props.sv */
// Port-level assertions for the clock control block
`timescale 1ns/1ps
module ckc_props (
	input wire logic clk,
	input wire logic sys_rst,
	input wire ckc_pkg::ckc_fuse_s fuses,
	input wire logic ctrl_wr,
	input wire logic [7:0] ctrl_wdata,
	input wire logic core_clk_level,
	input wire logic [7:0] pll_control_reg,
	input wire logic main_clock_select,
	input wire logic pll_enable,
	input wire logic pll_stable,
	input wire logic usb_clock_tick,
	input wire logic flash_clk_tick,
	input wire logic internal_reset,
	input wire logic src_reserved,
	input wire logic [3:0] src_onehot,
	input wire logic clock_output_pin,
	input wire logic clock_output_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	logic [3:0] src_exp;
	assign src_exp = fuses.src_b3 ? (fuses.src_b1 ? 4'h2 : 4'h1)
		: ((fuses.src_b2 | fuses.src_b1) ? 4'h8 : 4'h4);
	usb_needs_pll_a: assert property (
		usb_clock_tick |-> main_clock_select || $past(main_clock_select))
		else $error("usb tick without pll select");
	usb_halved_a: assert property (usb_clock_tick |=> !usb_clock_tick)
		else $error("usb tick on consecutive cycles");
	mux_base_a: assert property (
		internal_reset && $past(internal_reset) |-> !main_clock_select)
		else $error("pll selected during internal reset");
	src_decode_a: assert property (!internal_reset |-> src_onehot == src_exp)
		else $error("source decode wrong");
	src_reserved_a: assert property (!internal_reset |-> src_reserved == src_onehot[3])
		else $error("reserved flag wrong");
	stable_needs_en_a: assert property (pll_stable |-> pll_enable)
		else $error("stable without enable");
	lock_wait_a: assert property ($rose(pll_enable) |-> !pll_stable [*8])
		else $error("stable too early");
	ctrl_write_a: assert property (ctrl_wr && !internal_reset |=>
		main_clock_select == $past(ctrl_wdata[7]) && pll_enable == $past(ctrl_wdata[0]))
		else $error("control write not taken");
	reg_map_a: assert property (
		pll_control_reg == {main_clock_select, 5'h00, pll_stable, pll_enable})
		else $error("control register layout wrong");
	clk_out_a: assert property (!fuses.clk_out |=>
		clock_output_oe && clock_output_pin == $past(core_clk_level))
		else $error("clock output not driven");
	flash_rate_a: assert property (
		!internal_reset && flash_clk_tick |=> !flash_clk_tick ##1 flash_clk_tick)
		else $error("flash tick rate wrong");
endmodule
bind ckc_clock_source_startup_control ckc_props u_props (.clk(clk), .sys_rst(sys_rst),
	.fuses(fuses), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
	.core_clk_level(core_clk_level), .pll_control_reg(pll_control_reg),
	.main_clock_select(main_clock_select), .pll_enable(pll_enable),
	.pll_stable(pll_stable), .usb_clock_tick(usb_clock_tick),
	.flash_clk_tick(flash_clk_tick), .internal_reset(internal_reset),
	.src_reserved(src_reserved), .src_onehot(src_onehot),
	.clock_output_pin(clock_output_pin), .clock_output_oe(clock_output_oe));

/* testbench/testbench.sv */
// Self-checking bench for the clock source and start-up control block
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic sys_rst;
	ckc_pkg::ckc_fuse_s fuses;
	logic ext_reset_req, wake_req, wdt_osc_tick, osc_tick, recov_tick, core_clk_level;
	logic ctrl_wr;
	logic [7:0] ctrl_wdata, pll_control_reg;
	logic main_clock_select, pll_enable, pll_stable, base_clock_tick, usb_clock_tick;
	logic flash_clk_tick, internal_reset, startup_busy, src_reserved;
	logic clock_output_pin, clock_output_oe;
	logic [3:0] src_onehot;
	int err_total = 0;
	int compares = 0;
	int n, nu, nb, nf;
	// Fuse sets; zero span means the timing is not checked for that source
	logic [6:0] cfg [7] = '{7'h01, 7'h03, 7'h05, 7'h45, 7'h4B, 7'h21, 7'h58};
	int span [7] = '{90, 1114, 16474, 84, 90, 0, 0};
	int wake [7] = '{0, 42, 0, 40, 287, 0, 0};
	logic [3:0] oh [7] = '{4'h4, 4'h4, 4'h4, 4'h1, 4'h1, 4'h8, 4'h2};

	ckc_clock_source_startup_control u_dut (.clk, .sys_rst, .fuses, .ext_reset_req,
		.wake_req, .wdt_osc_tick, .osc_tick, .recov_tick, .core_clk_level, .ctrl_wr,
		.ctrl_wdata, .pll_control_reg, .main_clock_select, .pll_enable, .pll_stable,
		.base_clock_tick, .usb_clock_tick, .flash_clk_tick, .internal_reset,
		.startup_busy, .src_reserved, .src_onehot, .clock_output_pin, .clock_output_oe);
	ckc_osc_model u_osc (.clk, .osc_tick, .wdt_osc_tick, .recov_tick, .core_clk_level);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic near(input string nm, input int e, input int g, input int t);
		compares++;
		if (g < e - t || g > e + t) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] d);
		@(posedge clk);
		ctrl_wr <= 1'b1;
		ctrl_wdata <= d;
		@(posedge clk);
		ctrl_wr <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wait_low(input int lim);
		n = 0;
		@(negedge clk);
		while (internal_reset !== 1'b0 && n < lim) begin
			@(negedge clk);
			n++;
		end
		chk("reset_release", {7'h00, internal_reset}, 8'h00);
	endtask

	task automatic lock_wait;
		n = 0;
		while (pll_stable !== 1'b1 && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask

	task automatic tally(input int cyc);
		nu = 0;
		nb = 0;
		nf = 0;
		repeat (cyc) begin
			@(negedge clk);
			nu += (usb_clock_tick === 1'b1);
			nb += (base_clock_tick === 1'b1);
			nf += (flash_clk_tick === 1'b1);
		end
	endtask

	task automatic boot(input int i);
		@(posedge clk);
		sys_rst <= 1'b1;
		fuses <= cfg[i];
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		wait_low(40000);
		if (span[i] > 0) near("reset_span", span[i], n, 8);
		chk("src_onehot", {4'h0, src_onehot}, {4'h0, oh[i]});
		if (wake[i] > 0) begin
			@(posedge clk);
			wake_req <= 1'b1;
			@(posedge clk);
			wake_req <= 1'b0;
			n = 0;
			@(negedge clk);
			while (startup_busy === 1'b1 && n < 2000) begin
				@(negedge clk);
				n++;
			end
			near("wake_span", wake[i] * 2, n, 8);
		end
	endtask

	task automatic test_done;
		if (err_total == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	initial begin
		sys_rst = 1'b1;
		fuses = 7'h01;
		ext_reset_req = 1'b0;
		wake_req = 1'b0;
		ctrl_wr = 1'b0;
		ctrl_wdata = 8'h00;
		for (int k = 0; k < 7; k++) begin
			boot(k);
		end
		chk("clock_oe", {7'h00, clock_output_oe}, 8'h01);
		wr(8'h01);
		lock_wait;
		near("lock_span", ckc_pkg::LOCK_CYC + 1, n, 2);
		wr(8'h81);
		chk("ctrl_sel", pll_control_reg, 8'h83);
		tally(96);
		near("usb_ticks", 48, nu, 1);
		near("base_ticks", 8, nb, 1);
		near("flash_ticks", 48, nf, 1);
		wr(8'hFD);
		chk("ctrl_rsvd", pll_control_reg, 8'h83);
		wr(8'h01);
		tally(20);
		chk("usb_off", nu[7:0], 8'h00);
		wr(8'h00);
		chk("ctrl_off", pll_control_reg, 8'h00);
		wr(8'h01);
		chk("ctrl_reen", pll_control_reg, 8'h01);
		lock_wait;
		near("relock_span", ckc_pkg::LOCK_CYC + 1, n, 2);
		wr(8'h81);
		@(posedge clk);
		ext_reset_req <= 1'b1;
		repeat (3) @(negedge clk);
		chk("int_reset", {7'h00, internal_reset}, 8'h01);
		@(posedge clk);
		ext_reset_req <= 1'b0;
		wait_low(40000);
		chk("ctrl_boot", pll_control_reg, 8'h00);
		test_done;
	end

	initial begin
		repeat (90000) @(posedge clk);
		err_total++;
		$display("Error watchdog expected done seen timeout");
		test_done;
	end
endmodule
